// ### rtl/ocs_status_events.sv
// ocs_status_events: four overcurrent stages with status, blocking,
// timing, event scan and twelve operation records per stage.
// assumes currents and settings on clk_i, asynchronous block pins and
// an event buffer that takes every evt_o strobe.
`timescale 1ns/1ps
module ocs_status_events
    import ocs_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYC, // clocks per 5 ms tick
    parameter int unsigned MS_CYCLES   = MS_CYC    // clocks per 1 ms
) (
    input  wire logic                  clk_i,       // system clock
    input  wire logic                  srst_i,      // sync reset
    input  wire logic [NSTAGE-1:0]     blk_i,       // block pins
    input  wire logic [2:0][CUR_W-1:0] phase_cur_i, // currents A..C
    input  wire logic [H2_W-1:0]       h2_ratio_i,  // 2nd harmonic ratio
    input  wire ocs_cfg_t [NSTAGE-1:0] cfg_i,       // stage settings
    input  wire logic [1:0]            rec_stage_i, // record stage
    input  wire logic [3:0]            rec_idx_i,   // 0 is newest
    output ocs_stat_t [NSTAGE-1:0]     stat_o,      // stage status
    output logic                       evt_valid_o, // event strobe
    output ocs_evt_t                   evt_o,       // event data
    output logic [NSTAGE-1:0]          disp_evt_o,  // display event
    output ocs_rec_t                   rec_o,       // selected record
    output logic                       rec_valid_o  // record exists
);
    localparam int unsigned PW = $clog2(PROG_CYCLES + 1);
    localparam int unsigned MW = $clog2(MS_CYCLES + 1);
    localparam logic [PW-1:0] PROG_LAST = PW'(PROG_CYCLES - 1);
    localparam logic [MW-1:0] MS_LAST   = MW'(MS_CYCLES - 1);

    logic [PW-1:0]   prog_cnt, next_prog_cnt;
    logic [MW-1:0]   ms_cnt, next_ms_cnt;
    logic [TS_W-1:0] ts_ms, next_ts_ms, ts_tick, next_ts_tick;
    logic            tick, tick_d;
    logic [NSTAGE-1:0] blk_m, blk_s;

    // program tick and millisecond stamp dividers
    assign tick = (prog_cnt == PROG_LAST);

    always_comb begin
        next_prog_cnt = tick ? '0 : prog_cnt + 1'b1;
        next_ms_cnt   = (ms_cnt == MS_LAST) ? '0 : ms_cnt + 1'b1;
        next_ts_ms    = (ms_cnt == MS_LAST) ? ts_ms + 1'b1 : ts_ms;
        next_ts_tick  = tick ? ts_ms : ts_tick; // one stamp per tick
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            prog_cnt <= '0;
            ms_cnt   <= '0;
            ts_ms    <= '0;
            ts_tick  <= '0;
            tick_d   <= 1'b0;
            blk_m    <= '0;
            blk_s    <= '0;
        end else begin
            prog_cnt <= next_prog_cnt;
            ms_cnt   <= next_ms_cnt;
            ts_ms    <= next_ts_ms;
            ts_tick  <= next_ts_tick;
            tick_d   <= tick;
            blk_m    <= blk_i;   // pins are asynchronous
            blk_s    <= blk_m;
        end
    end

    // per stage state
    ocs_stage_t [NSTAGE-1:0] st_q, next_st;
    logic [CUR_W-1:0]        hist [NSTAGE][HDEPTH];

    always_comb begin
        logic [CUR_W-1:0]  im;
        logic [2:0]        pk;
        logic              blk, inr, run;
        logic [T_W-1:0]    el;
        logic [PROD_W-1:0] qr, qe;
        im      = '0;
        pk      = '0;
        blk     = 1'b0;
        inr     = 1'b0;
        run     = 1'b0;
        el      = '0;
        qr      = '0;
        qe      = '0;
        next_st = st_q;
        for (int s = 0; s < NSTAGE; s++) begin
            // highest phase current drives ratio and inverse time
            im = phase_cur_i[0];
            for (int p = 1; p < 3; p++)
                if (phase_cur_i[p] > im)
                    im = phase_cur_i[p];
            for (int p = 0; p < 3; p++)
                pk[p] = (phase_cur_i[p] > cfg_i[s].pickup) ||
                        (st_q[s].pick[p] &&
                         HYS_W'(phase_cur_i[p]) * PCT_FULL >
                         HYS_W'(cfg_i[s].pickup) * PCT_RESET);
            // zero setting would divide by zero: ratio then saturates
            qr = PROD_W'(R_MAX);
            if (cfg_i[s].pickup != '0)
                qr = PROD_W'(HYS_W'(im) * PCT_FULL) /
                     PROD_W'(cfg_i[s].pickup);
            next_st[s].ratio = (qr > PROD_W'(R_MAX)) ?
                               R_MAX : R_W'(qr);
            unique case (cfg_i[s].mode)
                OCS_INSTANT_MODE:       qe = '0;
                OCS_DEFINITE_TIME_MODE: qe = PROD_W'(cfg_i[s].op_delay);
                OCS_INVERSE_TIME_MODE:
                    qe = (im == '0) ? PROD_W'(T_MAX) :
                         (PROD_W'(cfg_i[s].op_delay) *
                          PROD_W'(cfg_i[s].pickup)) / PROD_W'(im);
                default:                qe = '0;
            endcase
            next_st[s].expt = (qe > PROD_W'(T_MAX)) ?
                              T_MAX : T_W'(qe);
            next_st[s].ln = cfg_i[s].ln_mode;
            // the pin level seen at the tick decides this cycle
            blk = blk_s[s] || (cfg_i[s].ln_mode == OCS_LN_BLK) ||
                  (cfg_i[s].ln_mode == OCS_LN_TBLK);
            inr = cfg_i[s].inrush_en &&
                  (h2_ratio_i > cfg_i[s].h2_limit);
            run = (|pk) && !blk;
            el  = st_q[s].elap;
            if (tick) begin
                next_st[s].pick  = pk;
                next_st[s].imax  = im;
                next_st[s].blkd  = (|pk) && blk;
                next_st[s].start = run;
                if (run) begin
                    if (!st_q[s].start && st_q[s].rel == '0)
                        next_st[s].pf = hist[s][HIST_200];
                    next_st[s].rel = '0;
                    if (el < T_MAX)
                        el = el + 1'b1;
                    // inrush holds back trip only, start stays
                    next_st[s].trip = (el >= st_q[s].expt) && !inr;
                    next_st[s].rem  = (st_q[s].expt > el) ?
                                      st_q[s].expt - el : '0;
                end else begin
                    // blocking and pick-up loss share release
                    next_st[s].trip = 1'b0;
                    next_st[s].rem  = '0;
                    if (st_q[s].start) begin
                        next_st[s].rel = cfg_i[s].rel_delay;
                        if (cfg_i[s].rel_delay == '0)
                            el = '0;
                    end else if (st_q[s].rel != '0) begin
                        next_st[s].rel = st_q[s].rel - 1'b1;
                        if (st_q[s].rel == T_W'(1))
                            el = '0;
                    end else begin
                        el = '0;
                    end
                end
                next_st[s].elap = el;
                if (cfg_i[s].ln_mode == OCS_LN_OFF) begin
                    next_st[s].pick  = '0;
                    next_st[s].start = 1'b0;
                    next_st[s].trip  = 1'b0;
                    next_st[s].blkd  = 1'b0;
                    next_st[s].elap  = '0;
                    next_st[s].rel   = '0;
                    next_st[s].rem   = '0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int s = 0; s < NSTAGE; s++)
                st_q[s] <= STAGE_RST;
        end else begin
            st_q <= next_st;
        end
    end

    // history of the highest current, newest in slot 0
    always_ff @(posedge clk_i) begin
        if (tick) begin
            for (int s = 0; s < NSTAGE; s++) begin
                hist[s][0] <= next_st[s].imax;
                for (int k = 1; k < HDEPTH; k++)
                    hist[s][k] <= hist[s][k-1];
            end
        end
    end

    // phase code: single phase 1..6, two phase 7..9 and 11..13, three phase 10, 14
    function automatic logic [3:0] ph_code(input logic [2:0] m,
                                           input logic       t);
        logic [3:0] c;
        c = 4'h0;
        unique case (m)
            3'b000: c = 4'h0;
            3'b001: c = 4'h1;
            3'b010: c = 4'h2;
            3'b100: c = 4'h3;
            3'b011: c = 4'h7;
            3'b110: c = 4'h8;
            3'b101: c = 4'h9;
            3'b111: c = 4'ha;
        endcase
        if (t && c != 4'h0)
            c = c + ((c < 4'h4) ? 4'h3 : 4'h4);
        return c;
    endfunction

    // status outputs decode registered state only
    logic [NSTAGE-1:0][NSIG-1:0] sv;

    always_comb begin
        for (int s = 0; s < NSTAGE; s++) begin
            stat_o[s].ln_behaviour = st_q[s].ln;
            stat_o[s].cond = st_q[s].trip  ? OCS_TRIP :
                             st_q[s].start ? OCS_START :
                             st_q[s].blkd  ? OCS_BLOCKED :
                                             OCS_NORMAL;
            stat_o[s].phase_cond = ph_code(st_q[s].start ? st_q[s].pick
                                                         : 3'b000,
                                           st_q[s].trip);
            stat_o[s].exp_time = st_q[s].expt;
            stat_o[s].rem_time = st_q[s].rem;
            stat_o[s].ratio    = st_q[s].ratio;
            stat_o[s].start    = st_q[s].start;
            stat_o[s].trip     = st_q[s].trip;
            stat_o[s].blocked  = st_q[s].blkd;
            sv[s] = {st_q[s].trip ? st_q[s].pick : 3'b000,
                     st_q[s].start ? st_q[s].pick : 3'b000,
                     st_q[s].blkd, st_q[s].trip, st_q[s].start};
        end
    end

    // event scan: one signal per clock, 36 clocks after each tick
    logic [NSTAGE-1:0][NSIG-1:0] new_q, next_new, chg_q, next_chg;
    logic                        scan_on, next_scan_on;
    logic [1:0]                  scan_stg, next_stg;
    logic [3:0]                  scan_sig, next_sig;
    logic                        scan_hit, scan_val;
    logic                        next_evt_valid;
    ocs_evt_t                    next_evt;
    logic [NSTAGE-1:0]           next_disp;

    assign scan_val = new_q[scan_stg][scan_sig];
    assign scan_hit = scan_on && chg_q[scan_stg][scan_sig];

    always_comb begin
        next_new       = new_q;
        next_chg       = chg_q;
        next_scan_on   = scan_on;
        next_stg       = scan_stg;
        next_sig       = scan_sig;
        next_evt_valid = 1'b0;
        next_evt       = evt_o;
        next_disp      = '0;
        if (tick_d) begin
            next_new = sv;
            for (int s = 0; s < NSTAGE; s++)
                next_chg[s] = sv[s] ^ new_q[s];
            next_scan_on = 1'b1;
            next_stg     = '0;
            next_sig     = '0;
        end else if (scan_on) begin
            if (scan_sig == SIG_LAST) begin
                next_sig = '0;
                next_stg = scan_stg + 1'b1;
                if (scan_stg == STG_LAST)
                    next_scan_on = 1'b0;
            end else begin
                next_sig = scan_sig + 1'b1;
            end
        end
        if (scan_hit && (scan_val ? cfg_i[scan_stg].evt_on_en
                                  : cfg_i[scan_stg].evt_off_en)) begin
            next_evt_valid = 1'b1;
            next_evt.stage = scan_stg;
            next_evt.sig   = scan_sig;
            next_evt.on    = scan_val;
            next_evt.fault = st_q[scan_stg].pick;
            next_evt.cur   = st_q[scan_stg].imax;
            next_evt.ts    = ts_tick;
        end
        // display event ignores the buffer filter
        if (scan_hit && scan_val && scan_sig == SIG_BLK)
            next_disp[scan_stg] = 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            new_q       <= '0;
            chg_q       <= '0;
            scan_on     <= 1'b0;
            scan_stg    <= '0;
            scan_sig    <= '0;
            evt_valid_o <= 1'b0;
            evt_o       <= '0;
            disp_evt_o  <= '0;
        end else begin
            new_q       <= next_new;
            chg_q       <= next_chg;
            scan_on     <= next_scan_on;
            scan_stg    <= next_stg;
            scan_sig    <= next_sig;
            evt_valid_o <= next_evt_valid;
            evt_o       <= next_evt;
            disp_evt_o  <= next_disp;
        end
    end

    // operation records, circular per stage
    ocs_rec_t                rec_mem [NSTAGE][NREC];
    ocs_rec_t                rec_new, next_rec;
    logic [NSTAGE-1:0][3:0]  wr_ptr, next_wr;
    logic [NSTAGE-1:0][4:0]  rec_cnt, next_cnt;
    logic                    rec_we, rd_ok;
    logic [4:0]              rd_sum, rd_fix;

    assign rec_we = scan_hit && scan_val && (scan_sig <= SIG_BLK);
    assign rd_sum = {1'b0, wr_ptr[rec_stage_i]} + NREC5 - 5'h01 -
                    {1'b0, rec_idx_i};
    assign rd_fix = (rd_sum >= NREC5) ? rd_sum - NREC5 : rd_sum;
    assign rd_ok  = ({1'b0, rec_idx_i} < rec_cnt[rec_stage_i]);

    always_comb begin
        rec_new.ts            = ts_tick;
        rec_new.evt           = scan_sig[1:0];
        rec_new.fault         = st_q[scan_stg].pick;
        rec_new.pre_trig      = hist[scan_stg][HIST_20];
        rec_new.fault_cur     = st_q[scan_stg].imax;
        rec_new.pre_fault     = st_q[scan_stg].pf;
        rec_new.rem           = st_q[scan_stg].rem;
        rec_new.setting_group = {1'b0, cfg_i[scan_stg].setting_group} + 4'h1;
        next_wr  = wr_ptr;
        next_cnt = rec_cnt;
        if (rec_we) begin
            next_wr[scan_stg] = (wr_ptr[scan_stg] == REC_LAST) ?
                                '0 : wr_ptr[scan_stg] + 1'b1;
            if (rec_cnt[scan_stg] != NREC5)
                next_cnt[scan_stg] = rec_cnt[scan_stg] + 1'b1;
        end
        next_rec = rd_ok ? rec_mem[rec_stage_i][rd_fix[3:0]] : '0;
    end

    always_ff @(posedge clk_i) begin
        if (rec_we)
            rec_mem[scan_stg][wr_ptr[scan_stg]] <= rec_new;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr      <= '0;
            rec_cnt     <= '0;
            rec_o       <= '0;
            rec_valid_o <= 1'b0;
        end else begin
            wr_ptr      <= next_wr;
            rec_cnt     <= next_cnt;
            rec_o       <= next_rec;
            rec_valid_o <= rd_ok;
        end
    end
endmodule // ocs_status_events

// ### rtl/ocs_pkg.sv
// ocs_pkg: constants, enumerations and packed carriers of the overcurrent
// stage status, blocking and event block; assumes one 40 MHz clock, no bus.
// Function
// - stage condition code: 0 normal, 1 start, 2 trip, 3 blocked
// - per-phase code 0..14 for start or trip of A..ABC
// - logical node behaviour 1 on .. 5 off follows the set mode
// - expected operating time in 5 ms steps, inverse follows highest current
// - remaining time to trip counts down in 5 ms steps, 1800 s max
// - highest phase current over pick-up setting, in 0.01 steps
// - block input sampled at the start of every program cycle
// - pick-up without blocking asserts start and runs trip timing
// - pick-up with blocking asserts blocked, no start or trip
// - blocking after start drops start and runs the release timing
// - optional second harmonic inrush block on trip only, default off
// - inrush blocks when harmonic ratio exceeds limit, up to 50.00 %
// - blocking gives a display event and a timestamped event with data
// - events on every change of start, trip, blocked, phase flags
// - per stage choice of ON, OFF or both events
// - four independent stages, each event tagged with its stage
// - last twelve timestamped records kept per stage
// - record only on ON of start, trip or blocked
// - record: time, event, fault, -20 ms, fault, -200 ms, remain, group
// - per phase pick-up above setting, release below 97 percent
// - 1 ms timestamps, instant start and trip share one stamp
package ocs_pkg;
    localparam int unsigned CLK_NS   = 25;             // 40 MHz clock
    localparam int unsigned PROG_NS  = 5000000;        // 5 ms program cycle
    localparam int unsigned PROG_CYC = PROG_NS / CLK_NS;
    localparam int unsigned MS_NS    = 1000000;        // 1 ms stamp step
    localparam int unsigned MS_CYC   = MS_NS / CLK_NS;
    localparam int unsigned NSTAGE   = 4;
    localparam int unsigned NREC     = 12;
    localparam int unsigned NSIG     = 9;
    localparam int unsigned CUR_W    = 16;             // current, 0.01 In
    localparam int unsigned T_W      = 19;             // time, 5 ms steps
    localparam int unsigned R_W      = 17;             // ratio, 0.01 steps
    localparam int unsigned H2_W     = 13;             // ratio, 0.01 %
    localparam int unsigned TS_W     = 32;             // stamp, ms
    localparam int unsigned HYS_W    = CUR_W + 7;
    localparam int unsigned PROD_W   = T_W + CUR_W;
    localparam int unsigned HDEPTH   = 40;             // 200 ms of history
    localparam int unsigned HIST_20  = 4;   // 20 ms back, after the shift
    localparam int unsigned HIST_200 = 39;  // 200 ms back, before the shift
    localparam logic [T_W-1:0]   T_MAX     = 19'h57e40; // 1800 s
    localparam logic [R_W-1:0]   R_MAX     = 17'h1e848; // 1250.00
    localparam logic [HYS_W-1:0] PCT_FULL  = 23'h000064; // 100 %
    localparam logic [HYS_W-1:0] PCT_RESET = 23'h000061; // 97 %
    localparam logic [H2_W-1:0]  H2_LIM_MAX = 13'h1388;  // 50.00 %
    localparam logic [3:0] SIG_START = 4'h0;  // event signal numbers
    localparam logic [3:0] SIG_TRIP  = 4'h1;
    localparam logic [3:0] SIG_BLK   = 4'h2;
    localparam logic [3:0] SIG_PSA   = 4'h3;  // phase start A, B, C
    localparam logic [3:0] SIG_PTA   = 4'h6;  // phase trip A, B, C
    localparam logic [3:0] SIG_LAST  = 4'h8;
    localparam logic [1:0] STG_LAST  = 2'h3;
    localparam logic [3:0] REC_LAST  = 4'hb;
    localparam logic [4:0] NREC5     = 5'h0c;

    typedef enum logic [1:0] {
        OCS_NORMAL  = 2'b00,
        OCS_START   = 2'b01,
        OCS_TRIP    = 2'b10,
        OCS_BLOCKED = 2'b11
    } ocs_cond_t;

    typedef enum logic [2:0] {
        OCS_LN_ON   = 3'b001,
        OCS_LN_BLK  = 3'b010,
        OCS_LN_TEST = 3'b011,
        OCS_LN_TBLK = 3'b100,
        OCS_LN_OFF  = 3'b101
    } ocs_ln_t;

    typedef enum logic [1:0] {
        OCS_INSTANT_MODE       = 2'b00,
        OCS_DEFINITE_TIME_MODE = 2'b01,
        OCS_INVERSE_TIME_MODE  = 2'b10
    } ocs_mode_t;

    typedef struct packed {
        logic [CUR_W-1:0] pickup;        // pick-up setting, 0.01 In
        logic [T_W-1:0]   op_delay;      // delay, or inverse multiplier
        logic [T_W-1:0]   rel_delay;     // release delay, 5 ms steps
        ocs_mode_t        mode;
        ocs_ln_t          ln_mode;
        logic             inrush_en;
        logic [H2_W-1:0]  h2_limit;      // 0.01 % of fundamental
        logic             evt_on_en;
        logic             evt_off_en;
        logic [2:0]       setting_group; // 0..7 for groups 1..8
    } ocs_cfg_t;

    typedef struct packed {
        ocs_ln_t          ln_behaviour;
        ocs_cond_t        cond;
        logic [3:0]       phase_cond;
        logic [T_W-1:0]   exp_time;
        logic [T_W-1:0]   rem_time;
        logic [R_W-1:0]   ratio;
        logic             start;
        logic             trip;
        logic             blocked;
    } ocs_stat_t;

    typedef struct packed {
        logic [1:0]       stage;
        logic [3:0]       sig;
        logic             on;
        logic [2:0]       fault;
        logic [CUR_W-1:0] cur;
        logic [TS_W-1:0]  ts;
    } ocs_evt_t;

    typedef struct packed {
        logic [TS_W-1:0]  ts;
        logic [1:0]       evt;
        logic [2:0]       fault;
        logic [CUR_W-1:0] pre_trig;
        logic [CUR_W-1:0] fault_cur;
        logic [CUR_W-1:0] pre_fault;
        logic [T_W-1:0]   rem;
        logic [3:0]       setting_group; // 1..8
    } ocs_rec_t;

    typedef struct packed {
        ocs_ln_t          ln;
        logic             start;
        logic             trip;
        logic             blkd;
        logic [2:0]       pick;   // bit 0 is phase A
        logic [T_W-1:0]   elap;
        logic [T_W-1:0]   rel;
        logic [T_W-1:0]   expt;
        logic [T_W-1:0]   rem;
        logic [R_W-1:0]   ratio;
        logic [CUR_W-1:0] imax;
        logic [CUR_W-1:0] pf;     // current 200 ms before start
    } ocs_stage_t;

    localparam ocs_stage_t STAGE_RST = '{ln: OCS_LN_ON, default: '0};
endpackage

// ### tb/ocs_assertions.sv
// ocs_checker: stage 0 status and event stream checks
// bound to ocs_status_events; one clock, sync reset
`timescale 1ns/1ps
module ocs_checker
    import ocs_pkg::*;
(
    input wire logic                   clk_i,       // clock
    input wire logic                   srst_i,      // reset
    input wire ocs_cfg_t [NSTAGE-1:0]  cfg_i,       // settings
    input wire ocs_stat_t [NSTAGE-1:0] stat_o,      // status
    input wire logic                   evt_valid_o, // strobe
    input wire ocs_evt_t               evt_o,       // event
    input wire logic [NSTAGE-1:0]      disp_evt_o   // display
);
    wire ocs_stat_t st = stat_o[0]; // stage 0 only, the others share the logic
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // counting towards trip, then the display strobe after a block
    sequence s_run; st.start && !st.trip && $past(st.start); endsequence
    sequence s_disp; ##[1:40] disp_evt_o[0]; endsequence
    property p_blk; st.blocked |-> st.cond == OCS_BLOCKED; endproperty
    property p_st; st.start && !st.trip |-> st.cond == OCS_START; endproperty
    property p_ex; st.blocked |-> !st.start && !st.trip; endproperty
    property p_ln;
        !$past(srst_i) |-> st.ln_behaviour == $past(cfg_i[0].ln_mode);
    endproperty
    property p_rem; st.trip |-> st.rem_time == '0; endproperty
    // inverse mode may jump when the current moves, so definite only
    property p_dec;
        s_run ##0 (cfg_i[0].mode == OCS_DEFINITE_TIME_MODE
        && $changed(st.rem_time)) |-> st.rem_time == $past(st.rem_time) - 1;
    endproperty
    property p_dsp; $rose(st.blocked) |-> s_disp; endproperty
    property p_flt;
        evt_valid_o |-> (evt_o.on ? cfg_i[evt_o.stage].evt_on_en
                                  : cfg_i[evt_o.stage].evt_off_en);
    endproperty
    a_blk: assert property (p_blk) else $error("blocked code");
    a_st: assert property (p_st) else $error("start code");
    a_ex: assert property (p_ex) else $error("start while blocked");
    a_ln: assert property (p_ln) else $error("node behaviour");
    a_rem: assert property (p_rem) else $error("remaining at trip");
    a_dec: assert property (p_dec) else $error("remaining step");
    a_dsp: assert property (p_dsp) else $error("no display event");
    a_flt: assert property (p_flt) else $error("filtered event");
endmodule // ocs_checker
bind ocs_status_events ocs_checker ocs_checker_i (.clk_i(clk_i),
    .srst_i(srst_i), .cfg_i(cfg_i), .stat_o(stat_o),
    .evt_valid_o(evt_valid_o), .evt_o(evt_o), .disp_evt_o(disp_evt_o));

// ### tb/ocs_event_sink.sv
// ocs_event_sink: event buffer side, tallies taken events
// assumes every strobe is taken at once; this buffer never stalls
`timescale 1ns/1ps
module ocs_event_sink
    import ocs_pkg::*;
(
    input  wire logic              clk_i,       // clock
    input  wire logic              srst_i,      // reset
    input  wire logic              evt_valid_i, // event strobe
    input  wire ocs_evt_t          evt_i,       // event data
    input  wire logic [NSTAGE-1:0] disp_i,      // display pulses
    output int                     own_cnt_o,   // stage 0 events
    output int                     oth_cnt_o,   // other stages
    output int                     disp_cnt_o   // stage 0 display
);
    // stage 0 kept apart so leaks between stages show
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            own_cnt_o  <= 0;
            oth_cnt_o  <= 0;
            disp_cnt_o <= 0;
        end else begin
            if (evt_valid_i && evt_i.stage == 2'h0)
                own_cnt_o <= own_cnt_o + 1;
            if (evt_valid_i && evt_i.stage != 2'h0)
                oth_cnt_o <= oth_cnt_o + 1;
            if (disp_i[0])
                disp_cnt_o <= disp_cnt_o + 1;
        end
    end
endmodule // ocs_event_sink

// ### tb/test_ocs_status_events.sv
// test_ocs_status_events: directed stage, event and record scenarios
// assumes a 64-clock program tick; inputs move mid-tick
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    miscompares++; $display("ERROR %0t got %0h", $time, a); end end
module test_ocs_status_events
    import ocs_pkg::*;
;
    logic                   clk_i, srst_i, evt_valid_o, rec_valid_o;
    logic [NSTAGE-1:0]      blk_i, disp_evt_o;
    logic [2:0][CUR_W-1:0]  phase_cur_i;
    logic [H2_W-1:0]        h2_ratio_i;
    ocs_cfg_t [NSTAGE-1:0]  cfg_i;
    logic [1:0]             rec_stage_i;
    logic [3:0]             rec_idx_i;
    ocs_stat_t [NSTAGE-1:0] stat_o;
    ocs_evt_t               evt_o;
    ocs_rec_t               rec_o;
    int own, oth, disp, comparisons = 0, miscompares = 0;
    ocs_status_events #(.PROG_CYCLES(64), .MS_CYCLES(16))
    ocs_status_events_i (.clk_i(clk_i), .srst_i(srst_i), .blk_i(blk_i),
        .phase_cur_i(phase_cur_i), .h2_ratio_i(h2_ratio_i), .cfg_i(cfg_i),
        .rec_stage_i(rec_stage_i), .rec_idx_i(rec_idx_i), .stat_o(stat_o),
        .evt_valid_o(evt_valid_o), .evt_o(evt_o), .disp_evt_o(disp_evt_o),
        .rec_o(rec_o), .rec_valid_o(rec_valid_o));
    ocs_event_sink ocs_event_sink_i (.clk_i(clk_i), .srst_i(srst_i),
        .evt_valid_i(evt_valid_o), .evt_i(evt_o), .disp_i(disp_evt_o),
        .own_cnt_o(own), .oth_cnt_o(oth), .disp_cnt_o(disp));
    // whole ticks keep every check half a tick away from the update
    task automatic tick(input int n);
        repeat (n * 64) @(negedge clk_i);
    endtask
    task automatic rd(input logic [1:0] s, input logic [3:0] i);
        rec_stage_i = s;
        rec_idx_i = i;
        repeat (2) @(negedge clk_i);
    endtask
    task automatic finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // definite delay of 3 ticks on phase A, then hysteresis
    task automatic t_trip;
        phase_cur_i[0] = 16'h00c8;
        tick(1);
        `CHK(stat_o[0].start, 1'b1)
        `CHK(stat_o[0].phase_cond, 4'h1)
        `CHK(stat_o[0].exp_time, 19'h00003)
        `CHK(stat_o[0].ratio, 17'h000c8)
        `CHK(stat_o[1].start, 1'b0)
        `CHK(stat_o[2].cond, OCS_NORMAL)
        `CHK(own, 2)
        tick(2);
        `CHK(stat_o[0].cond, OCS_TRIP)
        `CHK(stat_o[0].phase_cond, 4'h4)
        `CHK(own, 4)
        phase_cur_i[0] = 16'h0062;
        tick(1);
        `CHK(stat_o[0].trip, 1'b1)
        `CHK(stat_o[0].ratio, 17'h00062)
        $display("t_trip done");
    endtask
    // block arrives after the trip has expired; start and trip drop
    task automatic t_block;
        blk_i[0] = 1'b1;
        cfg_i[2] = '{pickup: 16'h0050, ln_mode: OCS_LN_ON, inrush_en: 1'b1,
            mode: OCS_INSTANT_MODE, h2_limit: 13'h05dc, default: '0};
        h2_ratio_i = 13'h05dd; // just above the limit
        tick(1);
        `CHK(stat_o[0].cond, OCS_BLOCKED)
        `CHK(stat_o[0].start, 1'b0)
        `CHK(disp, 1)
        `CHK(own, 5)
        `CHK(oth, 0)
        `CHK(stat_o[2].cond, OCS_START)
        $display("t_block done");
    endtask
    task automatic t_rec;
        rd(2'h0, 4'h0);
        `CHK(rec_o.evt, 2'h2)
        `CHK(rec_o.pre_trig, 16'h00c8)
        rd(2'h0, 4'h1);
        `CHK(rec_o.fault_cur, 16'h00c8)
        rd(2'h0, 4'h2);
        `CHK(rec_o.setting_group, 4'h4)
        `CHK(rec_o.rem, 19'h00002)
        rd(2'h0, 4'h3);
        `CHK(rec_valid_o, 1'b0)
        rd(2'h1, 4'h0);
        `CHK(rec_valid_o, 1'b0)
        $display("t_rec done");
    endtask
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // about 370 clocks are needed
    initial begin
        repeat (3000) @(posedge clk_i);
        miscompares++;
        finish_test;
    end
    // stage 1 off, stages 2 and 3 idle at first; inrush off
    initial begin
        srst_i = 1'b1;
        blk_i = '0;
        phase_cur_i = '0;
        h2_ratio_i = '0;
        rec_stage_i = '0;
        rec_idx_i = '0;
        cfg_i[0] = '{pickup: 16'h0064, op_delay: 19'h00003,
            mode: OCS_DEFINITE_TIME_MODE, ln_mode: OCS_LN_ON,
            evt_on_en: 1'b1, setting_group: 3'h3, default: '0};
        cfg_i[1] = cfg_i[0];
        cfg_i[1].ln_mode = OCS_LN_OFF;
        cfg_i[2] = cfg_i[0];
        cfg_i[2].pickup = 16'h0bb8;
        cfg_i[3] = cfg_i[2];
        repeat (10) @(negedge clk_i);
        srst_i = 1'b0;
        repeat (32) @(negedge clk_i);
        `CHK(stat_o[0].cond, OCS_NORMAL)
        `CHK(stat_o[1].ln_behaviour, OCS_LN_OFF)
        t_trip;
        t_block;
        t_rec;
        finish_test;
    end
endmodule // test_ocs_status_events
